// >>> verilog/dcc_pkg.sv
// constants, register map and state type of the dma channel controller
package dcc_pkg;

	// ------------------------------------------------------------
	// register offsets (byte addresses)
	// ------------------------------------------------------------
	localparam logic [7:0] OFS_CONFIG = 8'h44;
	localparam logic [7:0] OFS_COUNT  = 8'h48;
	localparam logic [7:0] OFS_PBASE  = 8'h4c;
	localparam logic [7:0] OFS_MBASE  = 8'h50;
	localparam logic [7:0] OFS_STATUS = 8'h54;
	localparam logic [7:0] OFS_MASK   = 8'h58;

	// ------------------------------------------------------------
	// configuration field positions
	// ------------------------------------------------------------
	localparam int CFG_W       = 15;
	localparam int BIT_M2M     = 14;
	localparam int BIT_PRIO_HI = 13;
	localparam int BIT_PRIO_LO = 12;
	localparam int BIT_MWID_HI = 11;
	localparam int BIT_MWID_LO = 10;
	localparam int BIT_PWID_HI = 9;
	localparam int BIT_PWID_LO = 8;
	localparam int BIT_MEMORY_INCREMENT    = 7;
	localparam int BIT_PERIPHERAL_INCREMENT    = 6;
	localparam int BIT_CYCLIC  = 5;
	localparam int BIT_DIR     = 4;
	localparam int BIT_ERR_IE  = 3;
	localparam int BIT_HALF_IE = 2;
	localparam int BIT_CPL_IE  = 1;
	localparam int BIT_EN      = 0;

	// ------------------------------------------------------------
	// status and mask bit positions, reset values
	// ------------------------------------------------------------
	localparam int ST_W        = 3;
	localparam int ST_COMPLETE = 0;
	localparam int ST_HALF     = 1;
	localparam int ST_ERROR    = 2;

	localparam logic [CFG_W-1:0] CONFIG_RST = 15'h0000;
	localparam logic [15:0]      COUNT_RST  = 16'h0000;
	localparam logic [31:0]      ADDR_RST   = 32'h0000_0000;
	localparam logic [ST_W-1:0]  STATUS_RST = 3'h0;

	// ------------------------------------------------------------
	// access width codes
	// ------------------------------------------------------------
	localparam logic [1:0] WID_BYTE = 2'h0;
	localparam logic [1:0] WID_HALF = 2'h1;
	localparam logic [1:0] WID_WORD = 2'h2;

	typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_WRITE} dcc_state_t;

endpackage : dcc_pkg

// >>> verilog/dcc_channel.sv
// one dma channel: configuration, transfer count, engine and apb registers
//
// Summary of operation
// - memory-to-memory bit 14 transfers without waiting for a request
// - memory width bits 11:10: byte, halfword, word; 11 reserved
// - peripheral width bits 9:8 use the same encoding
// - memory increment bit 7 advances memory address by its access size
// - peripheral increment bit 6 advances peripheral address by its size
// - cyclic bit 5 restarts the sequence automatically after completion
// - direction bit 4: clear reads peripheral, set reads memory
// - error interrupt raised only while bit 3 is set
// - half-transfer interrupt raised only while bit 2 is set
// - completion interrupt raised only while bit 1 is set
// - count register at 0x48 holds 16 bits, upper half zero, resets zero
// - count decrements by one after each completed transfer
// - at sequence end count becomes zero, or reloads in cyclic mode
// - a zero count moves no data even when enabled
//
// The implementer's own choice: the APB interface to the registers.
module dcc_channel
	import dcc_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        periph_req,
	output logic             periph_ack,
	output logic             bus_req,
	output logic             bus_write,
	output logic      [31:0] bus_addr,
	output logic      [1:0]  bus_size,
	output logic      [31:0] bus_wdata,
	input  wire logic [31:0] bus_rdata,
	input  wire logic        bus_ack,
	input  wire logic        bus_err,
	output logic      [1:0]  channel_priority,
	output logic             irq
);

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	// byte step of one access of the given width
	function automatic logic [31:0] size_step(input logic [1:0] wid);
		unique case (wid)
			WID_HALF: size_step = 32'h0000_0002;
			WID_WORD: size_step = 32'h0000_0004;
			default:  size_step = 32'h0000_0001;
		endcase
	endfunction : size_step

	// address forced onto the boundary of its access width
	function automatic logic [31:0] align(input logic [31:0] a,
			input logic [1:0] wid);
		unique case (wid)
			WID_HALF: align = {a[31:1], 1'b0};
			WID_WORD: align = {a[31:2], 2'b00};
			default:  align = a;
		endcase
	endfunction : align

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	logic [CFG_W-1:0] cfg_q;
	logic [15:0]      cnt_q;
	logic [15:0]      reload_q;
	logic [31:0]      pbase_q;
	logic [31:0]      mbase_q;
	logic [31:0]      pcur_q;
	logic [31:0]      mcur_q;
	logic [ST_W-1:0]  stat_q;
	logic [ST_W-1:0]  stat_d;
	logic [ST_W-1:0]  mask_q;
	logic [ST_W-1:0]  ie_bits;
	dcc_state_t       st_q;
	logic [31:0]      rd_d;
	logic             hit_d;
	logic             apb_wr;
	logic             start;
	logic             done;
	logic             last;
	logic             fault;
	logic             half;
	logic             src_mem;
	logic [1:0]       mwid;
	logic [1:0]       pwid;

	// ------------------------------------------------------------
	// decoded controls
	// ------------------------------------------------------------
	assign mwid    = cfg_q[BIT_MWID_HI:BIT_MWID_LO];
	assign pwid    = cfg_q[BIT_PWID_HI:BIT_PWID_LO];
	assign src_mem = cfg_q[BIT_DIR];
	assign apb_wr  = psel && penable && pready && pwrite;
	assign ie_bits = {cfg_q[BIT_ERR_IE], cfg_q[BIT_HALF_IE],
		cfg_q[BIT_CPL_IE]};

	// start needs enable, a nonzero count and a request or m2m mode
	assign start = (st_q == ST_IDLE) && cfg_q[BIT_EN] && (cnt_q != 16'h0000)
		&& (cfg_q[BIT_M2M] || periph_req);
	assign done  = (st_q == ST_WRITE) && bus_ack && !bus_err;
	assign fault = (st_q != ST_IDLE) && bus_ack && bus_err;
	assign last  = done && (cnt_q == 16'h0001);
	assign half  = done && ((cnt_q - 16'h0001) == (reload_q >> 1));

	// ------------------------------------------------------------
	// apb read decode
	// ------------------------------------------------------------
	// read mux; reserved bits read as zero, unmapped offsets flag an error
	always_comb begin
		rd_d  = 32'h0000_0000;
		hit_d = 1'b1;
		unique case (paddr)
			OFS_CONFIG: rd_d = {17'h00000, cfg_q};
			OFS_COUNT:  rd_d = {16'h0000, cnt_q};
			OFS_PBASE:  rd_d = pbase_q;
			OFS_MBASE:  rd_d = mbase_q;
			OFS_STATUS: rd_d = {29'h0000_0000, stat_q};
			OFS_MASK:   rd_d = {29'h0000_0000, mask_q};
			default:    hit_d = 1'b0;
		endcase
	end

	// one wait-free access phase: answer prepared during setup
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= 32'h0000_0000;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else if (psel && !penable) begin
			prdata  <= pwrite ? 32'h0000_0000 : rd_d;
			pready  <= 1'b1;
			pslverr <= !hit_d;
		end else begin
			prdata  <= 32'h0000_0000;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// configuration register
	// ------------------------------------------------------------
	// software writes; a bus error drops the enable
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_q <= CONFIG_RST;
		end else begin
			if (apb_wr && paddr == OFS_CONFIG)
				cfg_q <= pwdata[CFG_W-1:0];
			if (fault)
				cfg_q[BIT_EN] <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// transfer count
	// ------------------------------------------------------------
	// writes accepted only while disabled; decrement or reload per transfer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q    <= COUNT_RST;
			reload_q <= COUNT_RST;
		end else if (apb_wr && paddr == OFS_COUNT && !cfg_q[BIT_EN]) begin
			cnt_q    <= pwdata[15:0];
			reload_q <= pwdata[15:0];
		end else if (last && cfg_q[BIT_CYCLIC]) begin
			cnt_q <= reload_q;
		end else if (done) begin
			cnt_q <= cnt_q - 16'h0001;
		end
	end

	// ------------------------------------------------------------
	// address registers
	// ------------------------------------------------------------
	// base addresses written while disabled; current ones step per transfer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pbase_q <= ADDR_RST;
			mbase_q <= ADDR_RST;
			pcur_q  <= ADDR_RST;
			mcur_q  <= ADDR_RST;
		end else if (apb_wr && !cfg_q[BIT_EN]
				&& (paddr == OFS_PBASE || paddr == OFS_MBASE)) begin
			if (paddr == OFS_PBASE) begin
				pbase_q <= pwdata;
				pcur_q  <= pwdata;
			end else begin
				mbase_q <= pwdata;
				mcur_q  <= pwdata;
			end
		end else if (last && cfg_q[BIT_CYCLIC]) begin
			pcur_q <= pbase_q;
			mcur_q <= mbase_q;
		end else if (done) begin
			if (cfg_q[BIT_PERIPHERAL_INCREMENT])
				pcur_q <= pcur_q + size_step(pwid);
			if (cfg_q[BIT_MEMORY_INCREMENT])
				mcur_q <= mcur_q + size_step(mwid);
		end
	end

	// ------------------------------------------------------------
	// transfer engine
	// ------------------------------------------------------------
	// read from the source, then write to the destination
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q       <= ST_IDLE;
			bus_req    <= 1'b0;
			bus_write  <= 1'b0;
			bus_addr   <= ADDR_RST;
			bus_size   <= WID_BYTE;
			bus_wdata  <= 32'h0000_0000;
			periph_ack <= 1'b0;
		end else begin
			periph_ack <= 1'b0;
			unique case (st_q)
				ST_IDLE: begin
					if (start) begin
						st_q      <= ST_READ;
						bus_req   <= 1'b1;
						bus_write <= 1'b0;
						bus_addr  <= src_mem ? align(mcur_q, mwid)
							: align(pcur_q, pwid);
						bus_size  <= src_mem ? mwid : pwid;
					end
				end
				ST_READ: begin
					if (bus_ack && bus_err) begin
						st_q    <= ST_IDLE;
						bus_req <= 1'b0;
					end else if (bus_ack) begin
						st_q      <= ST_WRITE;
						bus_write <= 1'b1;
						bus_wdata <= bus_rdata;
						bus_addr  <= src_mem ? align(pcur_q, pwid)
							: align(mcur_q, mwid);
						bus_size  <= src_mem ? pwid : mwid;
					end
				end
				ST_WRITE: begin
					if (bus_ack) begin
						st_q       <= ST_IDLE;
						bus_req    <= 1'b0;
						bus_write  <= 1'b0;
						periph_ack <= !bus_err && !cfg_q[BIT_M2M];
					end
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// status, mask and interrupt
	// ------------------------------------------------------------
	// sticky events; a new event wins over a write-one clear
	always_comb begin
		stat_d = stat_q;
		if (apb_wr && paddr == OFS_STATUS)
			stat_d = stat_q & ~pwdata[ST_W-1:0];
		stat_d[ST_COMPLETE] = stat_d[ST_COMPLETE] | last;
		stat_d[ST_HALF]     = stat_d[ST_HALF] | half;
		stat_d[ST_ERROR]    = stat_d[ST_ERROR] | fault;
	end

	// status, mask, and the gated interrupt level
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stat_q <= STATUS_RST;
			mask_q <= STATUS_RST;
			irq    <= 1'b0;
		end else begin
			stat_q <= stat_d;
			if (apb_wr && paddr == OFS_MASK)
				mask_q <= pwdata[ST_W-1:0];
			irq <= |(stat_d & mask_q & ie_bits);
		end
	end

	// priority is only exported to the arbiter
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			channel_priority <= 2'h0;
		else
			channel_priority <= cfg_q[BIT_PRIO_HI:BIT_PRIO_LO];
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence read_taken;
		st_q == ST_READ && bus_ack && !bus_err;
	endsequence

	sequence write_issued;
		st_q == ST_WRITE && bus_req && bus_write;
	endsequence

	count_step_a: assert property (done && cnt_q != 16'h0001
		&& !apb_wr |=> cnt_q == $past(cnt_q) - 16'h0001)
		else $error("count did not decrement after a transfer");

	cyclic_reload_a: assert property (last && cfg_q[BIT_CYCLIC]
		|=> cnt_q == $past(reload_q) && pcur_q == $past(pbase_q))
		else $error("cyclic mode did not reload");

	end_zero_a: assert property (last && !cfg_q[BIT_CYCLIC]
		|=> cnt_q == 16'h0000 ##1 !bus_req)
		else $error("count not zero at sequence end");

	zero_idle_a: assert property (st_q == ST_IDLE
		&& cnt_q == 16'h0000 |=> !bus_req)
		else $error("transfer started with zero count");

	m2m_start_a: assert property (start && cfg_q[BIT_M2M]
		&& !periph_req |=> bus_req && !bus_write)
		else $error("memory-to-memory transfer did not start");

	periph_wait_a: assert property (st_q == ST_IDLE
		&& !cfg_q[BIT_M2M] && !periph_req |=> !bus_req)
		else $error("transfer started without a peripheral request");

	read_side_a: assert property (st_q == ST_IDLE && start
		|=> bus_addr == ($past(src_mem) ? align($past(mcur_q), $past(mwid))
			: align($past(pcur_q), $past(pwid))))
		else $error("read issued at the wrong side");

	read_size_a: assert property (bus_req && !bus_write
		|-> bus_size == (src_mem ? mwid : pwid))
		else $error("read access width mismatch");

	write_follows_a: assert property (read_taken |=> write_issued)
		else $error("write did not follow a completed read");

	mem_step_a: assert property (done && !last && !apb_wr
		|=> mcur_q == $past(mcur_q)
			+ ($past(cfg_q[BIT_MEMORY_INCREMENT]) ? size_step($past(mwid)) : 32'h0))
		else $error("memory address step wrong");

	per_step_a: assert property (done && !last && !apb_wr
		|=> pcur_q == $past(pcur_q)
			+ ($past(cfg_q[BIT_PERIPHERAL_INCREMENT]) ? size_step($past(pwid)) : 32'h0))
		else $error("peripheral address step wrong");

	irq_gate_a: assert property (irq
		|-> $past(|(stat_d & mask_q & ie_bits)))
		else $error("interrupt without an enabled event");

	count_upper_a: assert property (psel && !penable && !pwrite
		&& paddr == OFS_COUNT |=> prdata[31:16] == 16'h0000)
		else $error("count upper half not zero");

	count_lock_a: assert property (apb_wr && paddr == OFS_COUNT
		&& cfg_q[BIT_EN] && !done |=> cnt_q == $past(cnt_q))
		else $error("count written while enabled");

endmodule : dcc_channel

// >>> tb/dcc_bus_model.sv
// system bus memory model with adjustable answer delay and error injection
module dcc_bus_model (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        bus_req,
	input  wire logic        bus_write,
	input  wire logic [31:0] bus_addr,
	input  wire logic [31:0] bus_wdata,
	input  wire logic [3:0]  wait_n,
	input  wire logic        fail,
	output logic      [31:0] bus_rdata,
	output logic             bus_ack,
	output logic             bus_err
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [31:0] mem [0:63];
	logic [3:0]  cnt_q;

	// one ack per held request after wait_n cycles; idle read data toggles
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q <= 4'h0;
			bus_ack <= 1'b0;
			bus_err <= 1'b0;
			bus_rdata <= 32'h0;
		end else if (bus_req && !bus_ack && cnt_q >= wait_n) begin
			bus_ack <= 1'b1;
			bus_err <= fail;
			cnt_q <= 4'h0;
			bus_rdata <= mem[bus_addr[7:2]];
			if (bus_write && !fail)
				mem[bus_addr[7:2]] <= bus_wdata;
		end else begin
			bus_ack <= 1'b0;
			bus_err <= 1'b0;
			cnt_q <= (bus_req && !bus_ack) ? cnt_q + 4'h1 : 4'h0;
			bus_rdata <= ~bus_rdata;
		end
	end
endmodule : dcc_bus_model

// >>> tb/dcc_channel_bench.sv
// self-checking bench for the dma channel controller
module dcc_channel_bench;
	import dcc_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;

	logic        pclk, presetn, psel, penable, pwrite, periph_req;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, bus_addr, bus_wdata, bus_rdata;
	logic        pready, pslverr, periph_ack, bus_req, bus_write;
	logic        bus_ack, bus_err, irq, fail, e;
	logic [1:0]  bus_size, channel_priority, rd_size, wr_size;
	logic [31:0] rd_addr, wr_addr, q;
	logic [3:0]  wait_n;
	int          mismatches = 0;
	int          tests_run = 0;
	int          acks = 0;
	int          reqs = 0;
	int          a0;

	dcc_channel u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.periph_req(periph_req), .periph_ack(periph_ack), .bus_req(bus_req),
		.bus_write(bus_write), .bus_addr(bus_addr), .bus_size(bus_size),
		.bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .bus_ack(bus_ack),
		.bus_err(bus_err), .channel_priority(channel_priority), .irq(irq));

	dcc_bus_model u_mem (.pclk(pclk), .presetn(presetn), .bus_req(bus_req),
		.bus_write(bus_write), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
		.wait_n(wait_n), .fail(fail), .bus_rdata(bus_rdata),
		.bus_ack(bus_ack), .bus_err(bus_err));

	// -----------------------------------------------------------------
	// clock and bus monitors
	// -----------------------------------------------------------------
	initial begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end

	// record last read and write access, count acks and busy cycles
	always @(posedge pclk) begin
		if (bus_ack === 1'b1 && bus_write === 1'b1) begin
			wr_addr <= bus_addr;
			wr_size <= bus_size;
		end else if (bus_ack === 1'b1) begin
			rd_addr <= bus_addr;
			rd_size <= bus_size;
		end
		if (periph_ack === 1'b1)
			acks <= acks + 1;
		if (bus_req === 1'b1)
			reqs <= reqs + 1;
	end

	// -----------------------------------------------------------------
	// tasks
	// -----------------------------------------------------------------
	task check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			mismatches++;
			$display("CHECK FAILED t=%0t saw %h want %h", $time, seen, exp);
		end
	endtask : check

	task tally_and_finish;
		$display("compares %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : tally_and_finish

	task hung;
		mismatches++;
		$display("CHECK FAILED t=%0t wait ran out", $time);
		tally_and_finish;
	endtask : hung

	// one apb transfer; read data and error land in q and e
	task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1)
			hung;
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task rd_chk(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		check(q, exp);
	endtask : rd_chk

	task wait_irq;
		int n;
		n = 0;
		while (irq !== 1'b1 && n < 400) begin
			@(posedge pclk);
			n++;
		end
		if (irq !== 1'b1)
			hung;
		repeat (3) @(posedge pclk);
	endtask : wait_irq

	// program count, bases, mask, then config with enable
	task start(input logic [31:0] cnt, input logic [31:0] pb,
		input logic [31:0] mb, input logic [31:0] cfg);
		apb(1'b1, OFS_COUNT, cnt);
		apb(1'b1, OFS_PBASE, pb);
		apb(1'b1, OFS_MBASE, mb);
		apb(1'b1, OFS_MASK, 32'h7);
		apb(1'b1, OFS_CONFIG, cfg);
	endtask : start

	// -----------------------------------------------------------------
	// main sequence
	// -----------------------------------------------------------------
	initial begin
		{psel, penable, pwrite, periph_req, fail} = 5'h00;
		paddr = 8'h00;
		pwdata = 32'h0;
		wait_n = 4'h2;
		presetn = 1'b0;
		for (int i = 0; i < 64; i++)
			u_mem.mem[i] = 32'hc0de_0000 | 32'(i);
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		rd_chk(OFS_CONFIG, 32'h0);
		rd_chk(OFS_COUNT, 32'h0);
		apb(1'b1, OFS_COUNT, 32'hffff_2345);
		rd_chk(OFS_COUNT, 32'h0000_2345);
		apb(1'b1, 8'h40, 32'h1);
		check({31'h0, e}, 32'h1);
		apb(1'b1, OFS_CONFIG, 32'hffff_7ffe);
		rd_chk(OFS_CONFIG, 32'h0000_7ffe);
		check({30'h0, channel_priority}, 32'h3);
		apb(1'b1, OFS_CONFIG, 32'h0);
		a0 = reqs;
		start(32'h0, 32'h0, 32'h40, 32'h4001);
		repeat (20) @(posedge pclk);
		check(reqs, a0);
		apb(1'b1, OFS_CONFIG, 32'h0);
		$display("test registers done");
		periph_req <= 1'b1;
		a0 = acks;
		start(32'h4, 32'h0, 32'h40, 32'h0ac3);
		wait_irq;
		for (int i = 0; i < 4; i++)
			check(u_mem.mem[16+i], 32'hc0de_0000 | 32'(i));
		rd_chk(OFS_COUNT, 32'h0);
		check(acks - a0, 4);
		rd_chk(OFS_STATUS, 32'h3);
		apb(1'b1, OFS_STATUS, 32'h1);
		repeat (3) @(posedge pclk);
		check({31'h0, irq}, 32'h0);
		apb(1'b1, OFS_CONFIG, 32'h0ac7);
		repeat (3) @(posedge pclk);
		check({31'h0, irq}, 32'h1);
		periph_req <= 1'b0;
		apb(1'b1, OFS_STATUS, 32'h7);
		apb(1'b1, OFS_CONFIG, 32'h0);
		$display("test peripheral to memory done");
		wait_n <= 4'h0;
		start(32'h2, 32'h60, 32'h50, 32'h4693);
		wait_irq;
		check(rd_addr, 32'h52);
		check({30'h0, rd_size}, 32'h1);
		check(wr_addr, 32'h60);
		check({30'h0, wr_size}, 32'h2);
		apb(1'b1, OFS_COUNT, 32'h5);
		rd_chk(OFS_COUNT, 32'h0);
		apb(1'b1, OFS_STATUS, 32'h7);
		apb(1'b1, OFS_CONFIG, 32'h0);
		$display("test memory to memory done");
		fail <= 1'b1;
		start(32'h3, 32'h0, 32'h40, 32'h4a89);
		wait_irq;
		fail <= 1'b0;
		rd_chk(OFS_STATUS, 32'h4);
		rd_chk(OFS_CONFIG, 32'h4a88);
		rd_chk(OFS_COUNT, 32'h3);
		apb(1'b1, OFS_STATUS, 32'h4);
		repeat (3) @(posedge pclk);
		check({31'h0, irq}, 32'h0);
		$display("test bus error done");
		wait_n <= 4'h1;
		periph_req <= 1'b1;
		a0 = acks;
		start(32'h2, 32'h0, 32'h40, 32'h0a23);
		for (int n = 0; n < 400 && acks < a0 + 5; n++)
			@(posedge pclk);
		check(acks >= a0 + 5, 1);
		periph_req <= 1'b0;
		repeat (20) @(posedge pclk);
		apb(1'b0, OFS_STATUS, 32'h0);
		check(q & 32'h1, 32'h1);
		apb(1'b1, OFS_CONFIG, 32'h0);
		$display("test cyclic done");
		tally_and_finish;
	end
endmodule : dcc_channel_bench
